//--- include/adcsc_pkg.sv
`default_nettype none
package adcsc_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int CH_NUM = 12;
	localparam int CH_W   = 4;
	localparam int IRQ_W  = 3;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_START   = 8'h00;
	localparam logic [7:0] OFS_SCAN    = 8'h04;
	localparam logic [7:0] OFS_REF     = 8'h08;
	localparam logic [7:0] OFS_CLKDIV  = 8'h0C;
	localparam logic [7:0] OFS_SRST    = 8'h10;
	localparam logic [7:0] OFS_HOLD    = 8'h14;
	localparam logic [7:0] OFS_STAT    = 8'h18;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h20;
	localparam logic [1:0] OFS_SLOT_HI = 2'h1;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int START_GO     = 0;
	localparam int START_RPT    = 1;
	localparam int START_SCAN   = 2;
	localparam int START_HP     = 3;
	localparam int SCAN_CNT_LSB = 4;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_EOC     = 1;
	localparam int STAT_HPEOC   = 2;
	localparam int IRQ_DONE     = 0;
	localparam int IRQ_REFUSE   = 1;
	localparam int IRQ_HP       = 2;
	// ------------------------------------------------------------
	// values after reset and codes
	// ------------------------------------------------------------
	localparam logic [3:0] RST_FIRST  = 4'h0;
	localparam logic [3:0] RST_COUNT  = 4'hC;
	localparam logic [2:0] RST_CLKDIV = 3'h2;
	localparam logic [6:0] SH_MIN     = 7'h0A;
	localparam logic [6:0] SH_MAX     = 7'h50;
	localparam logic [1:0] SRST_ARM   = 2'h2;
	localparam logic [1:0] SRST_FIRE  = 2'h1;
	localparam int         CONV_CYC   = 14;

	typedef struct packed {
		logic [3:0] first;
		logic [3:0] count;
		logic       rpt;
		logic       scan;
		logic [6:0] hold;
	} adcsc_cfg_t;
endpackage : adcsc_pkg
`default_nettype wire

//--- hw/adcsc_clkdiv.sv
`default_nettype none
module adcsc_clkdiv
	import adcsc_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_restart,
	input  wire logic [2:0] i_div_sel,
	output logic            o_tick
);
	logic [3:0] cnt_q;
	logic [3:0] last;

	// code n divides by 2n, code 0 by 2
	assign last = (i_div_sel == 3'h0) ? 4'h1 : {i_div_sel, 1'b0} - 4'h1;

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cnt_q  <= 4'h0;
			o_tick <= 1'b0;
		end
		else if (i_restart)
		begin
			cnt_q  <= 4'h0;
			o_tick <= 1'b0;
		end
		else if (cnt_q >= last)
		begin
			cnt_q  <= 4'h0;
			o_tick <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 4'h1;
			o_tick <= 1'b0;
		end
	end
endmodule : adcsc_clkdiv
`default_nettype wire

//--- hw/adcsc_sampler.sv
`default_nettype none
module adcsc_sampler
	import adcsc_pkg::*;
#(
	parameter int CONV_TICKS = CONV_CYC
)
(
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_tick,
	input  wire logic       i_abort,
	input  wire logic       i_start,
	input  wire logic [6:0] i_hold,
	output logic            o_sampling,
	output logic            o_converting,
	output logic            o_done
);
	typedef enum logic [1:0] {
		SM_IDLE = 2'b00,
		SM_HOLD = 2'b01,
		SM_CONV = 2'b10
	} adcsc_sm_t;

	adcsc_sm_t  st_q;
	logic [6:0] cnt_q;

	// ------------------------------------------------------------
	// sample-hold then conversion, counted in converter ticks
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_q         <= SM_IDLE;
			cnt_q        <= 7'h00;
			o_sampling   <= 1'b0;
			o_converting <= 1'b0;
			o_done       <= 1'b0;
		end
		else if (i_abort)
		begin
			st_q         <= SM_IDLE;
			cnt_q        <= 7'h00;
			o_sampling   <= 1'b0;
			o_converting <= 1'b0;
			o_done       <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			unique case (st_q)
				SM_IDLE:
				begin
					if (i_start)
					begin
						st_q       <= SM_HOLD;
						cnt_q      <= 7'h00;
						o_sampling <= 1'b1;
					end
				end
				SM_HOLD:
				begin
					if (i_tick)
					begin
						if (cnt_q == i_hold - 7'h01)
						begin
							st_q         <= SM_CONV;
							cnt_q        <= 7'h00;
							o_sampling   <= 1'b0;
							o_converting <= 1'b1;
						end
						else
							cnt_q <= cnt_q + 7'h01;
					end
				end
				SM_CONV:
				begin
					if (i_tick)
					begin
						if (cnt_q == 7'(CONV_TICKS - 1))
						begin
							st_q         <= SM_IDLE;
							o_converting <= 1'b0;
							o_done       <= 1'b1;
						end
						else
							cnt_q <= cnt_q + 7'h01;
					end
				end
				default:
					st_q <= SM_IDLE;
			endcase
		end
	end
endmodule : adcsc_sampler
`default_nettype wire

//--- hw/adcsc_ctrl.sv
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
module adcsc_ctrl
	import adcsc_pkg::*;
#(
	parameter int RES_W = 12
)
(
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	input  wire logic             i_hsel,
	input  wire logic [31:0]      i_haddr,
	input  wire logic [1:0]       i_htrans,
	input  wire logic             i_hwrite,
	input  wire logic [2:0]       i_hsize,
	input  wire logic [31:0]      i_hwdata,
	input  wire logic             i_hready,
	input  wire logic [RES_W-1:0] i_conv_data,
	output logic [31:0]           o_hrdata,
	output logic                  o_hreadyout,
	output logic                  o_hresp,
	output logic                  o_irq,
	output logic [CH_W-1:0]       o_analog_input_channel,
	output logic                  o_sample_hold,
	output logic                  o_converting,
	output logic                  o_reference_power_on
);
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_CONV = 1'b1
	} adcsc_st_t;

	adcsc_cfg_t       cfg_q;
	adcsc_st_t        st_q;
	logic [2:0]       clkdiv_q;
	logic             pend_q, wr_q, rd_q;
	logic [7:0]       addr_q;
	logic [31:0]      rdata;
	logic             wr_en, rd_en, go, hp_go, start_ok, range_ok;
	logic             scan_now;
	logic [6:0]       hold_ticks_q;
	logic [4:0]       span;
	logic [CH_W-1:0]  last_q, slot_idx;
	logic             hp_mode_q, kick_q, armed_q, srst_q;
	logic             tick, done, pass_done, hp_done, refuse;
	logic             eoc_q, hpeoc_q;
	logic [IRQ_W-1:0] irq_st_q, irq_msk_q, irq_ev;
	logic [RES_W-1:0] slot_q [CH_NUM];

	// ------------------------------------------------------------
	// bus slave: one wait state per transfer, always OKAY
	// ------------------------------------------------------------
	assign o_hresp = 1'b0;
	assign wr_en   = pend_q & wr_q;
	assign rd_en   = pend_q & rd_q;

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			pend_q      <= 1'b0;
			wr_q        <= 1'b0;
			rd_q        <= 1'b0;
			addr_q      <= 8'h00;
			o_hreadyout <= 1'b1;
		end
		else if (i_hsel && i_htrans[1] && i_hready)
		begin
			pend_q      <= 1'b1;
			wr_q        <= i_hwrite && (i_hsize == 3'h2);
			rd_q        <= !i_hwrite;
			addr_q      <= i_haddr[7:0];
			o_hreadyout <= 1'b0;
		end
		else if (pend_q)
		begin
			pend_q      <= 1'b0;
			o_hreadyout <= 1'b1;
		end
	end

	assign slot_idx = addr_q[5:2];

	always_comb
	begin
		rdata = 32'h0000_0000;
		if (addr_q[7:6] == OFS_SLOT_HI)
		begin
			if (slot_idx < CH_W'(CH_NUM))
				rdata = 32'(slot_q[slot_idx]);
		end
		else
		begin
			unique case (addr_q)
				OFS_START:   rdata = 32'({cfg_q.scan, cfg_q.rpt, 1'b0});
				OFS_SCAN:    rdata = 32'({cfg_q.count, cfg_q.first});
				OFS_REF:     rdata = 32'(o_reference_power_on);
				OFS_CLKDIV:  rdata = 32'(clkdiv_q);
				OFS_HOLD:    rdata = 32'(cfg_q.hold);
				OFS_STAT:    rdata = 32'({hpeoc_q, eoc_q, st_q});
				OFS_IRQ_ST:  rdata = 32'(irq_st_q);
				OFS_IRQ_MSK: rdata = 32'(irq_msk_q);
				default:     rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_hrdata <= 32'h0000_0000;
		else if (rd_en)
			o_hrdata <= rdata;
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cfg_q.first          <= RST_FIRST;
			cfg_q.count          <= RST_COUNT;
			cfg_q.rpt            <= 1'b0;
			cfg_q.scan           <= 1'b0;
			cfg_q.hold           <= SH_MIN;
			clkdiv_q             <= RST_CLKDIV;
			o_reference_power_on <= 1'b0;
		end
		else if (wr_en)
		begin
			unique case (addr_q)
				OFS_START:
				begin
					cfg_q.rpt  <= i_hwdata[START_RPT];
					cfg_q.scan <= i_hwdata[START_SCAN];
				end
				OFS_SCAN:
				begin
					cfg_q.first <= i_hwdata[3:0];
					cfg_q.count <= i_hwdata[SCAN_CNT_LSB +: 4];
				end
				OFS_REF:    o_reference_power_on <= i_hwdata[0];
				OFS_CLKDIV: clkdiv_q             <= i_hwdata[2:0];
				OFS_HOLD:
				begin
					if (i_hwdata[31:7] != 25'h0 || i_hwdata[6:0] > SH_MAX)
						cfg_q.hold <= SH_MAX;
					else if (i_hwdata[6:0] < SH_MIN)
						cfg_q.hold <= SH_MIN;
					else
						cfg_q.hold <= i_hwdata[6:0];
				end
				default:
				begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// soft reset pair
	// ------------------------------------------------------------
	// arm on 10, fire on 01
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			armed_q <= 1'b0;
			srst_q  <= 1'b0;
		end
		else
		begin
			srst_q <= 1'b0;
			if (wr_en && addr_q == OFS_SRST)
			begin
				armed_q <= (i_hwdata[1:0] == SRST_ARM);
				srst_q  <= armed_q && (i_hwdata[1:0] == SRST_FIRE);
			end
		end
	end

	// ------------------------------------------------------------
	// start decode and scan sequencer
	// ------------------------------------------------------------
	assign go    = wr_en && addr_q == OFS_START && i_hwdata[START_GO];
	assign hp_go = wr_en && addr_q == OFS_START && i_hwdata[START_HP];
	// a start honours the scan bit written along with it
	assign scan_now = (wr_en && addr_q == OFS_START)
		? i_hwdata[START_SCAN] : cfg_q.scan;
	assign span  = {1'b0, cfg_q.first} + {1'b0, cfg_q.count};
	// count limited to twelve minus first
	assign range_ok = cfg_q.count != 4'h0 && span <= 5'(CH_NUM);
	assign start_ok = st_q == ST_IDLE && cfg_q.first < CH_W'(CH_NUM)
		&& (!scan_now || hp_go || range_ok);
	assign refuse    = (go || hp_go) && !start_ok;
	assign pass_done = st_q == ST_CONV && done
		&& o_analog_input_channel == last_q && !hp_mode_q;
	assign hp_done   = st_q == ST_CONV && done && hp_mode_q;

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_q                   <= ST_IDLE;
			o_analog_input_channel <= '0;
			last_q                 <= '0;
			hp_mode_q              <= 1'b0;
			kick_q                 <= 1'b0;
		end
		else if (srst_q)
		begin
			st_q   <= ST_IDLE;
			kick_q <= 1'b0;
		end
		else
		begin
			kick_q <= 1'b0;
			unique case (st_q)
				ST_IDLE:
				begin
					if ((go || hp_go) && start_ok)
					begin
						st_q                   <= ST_CONV;
						kick_q                 <= 1'b1;
						hp_mode_q              <= hp_go;
						o_analog_input_channel <= cfg_q.first;
						last_q                 <= (scan_now && !hp_go)
							? cfg_q.first + cfg_q.count - 4'h1
							: cfg_q.first;
					end
				end
				ST_CONV:
				begin
					if (done)
					begin
						kick_q <= 1'b1;
						if (o_analog_input_channel != last_q)
							o_analog_input_channel <=
								o_analog_input_channel + 4'h1;
						else if (cfg_q.rpt && !hp_mode_q)
							o_analog_input_channel <= cfg_q.first;
						else
						begin
							st_q   <= ST_IDLE;
							kick_q <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	adcsc_clkdiv u_clkdiv (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_restart (srst_q),
		.i_div_sel (clkdiv_q),
		.o_tick    (tick)
	);

	adcsc_sampler #(.CONV_TICKS(CONV_CYC)) u_sampler (
		.i_clk        (i_clk),
		.i_arst_n     (i_arst_n),
		.i_tick       (tick),
		.i_abort      (srst_q),
		.i_start      (kick_q),
		.i_hold       (cfg_q.hold),
		.o_sampling   (o_sample_hold),
		.o_converting (o_converting),
		.o_done       (done)
	);

	// ------------------------------------------------------------
	// result slots
	// ------------------------------------------------------------
	for (genvar i = 0; i < CH_NUM; i++)
	begin : g_slot
		always_ff @(posedge i_clk or negedge i_arst_n)
		begin
			if (!i_arst_n)
				slot_q[i] <= '0;
			else if (srst_q)
				slot_q[i] <= '0;
			else if (st_q == ST_CONV && done
				&& o_analog_input_channel == CH_W'(i))
				slot_q[i] <= i_conv_data;
		end
	end

	// ------------------------------------------------------------
	// completion flags and interrupts
	// ------------------------------------------------------------
	// read clears, a new event wins
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			eoc_q   <= 1'b0;
			hpeoc_q <= 1'b0;
		end
		else if (pass_done || hp_done)
		begin
			eoc_q   <= eoc_q | pass_done;
			hpeoc_q <= hpeoc_q | hp_done;
		end
		else if (srst_q || (rd_en && addr_q == OFS_STAT))
		begin
			eoc_q   <= 1'b0;
			hpeoc_q <= 1'b0;
		end
	end

	assign irq_ev = {hp_done, refuse, pass_done};

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			irq_st_q  <= '0;
			irq_msk_q <= '0;
			o_irq     <= 1'b0;
		end
		else
		begin
			if (wr_en && addr_q == OFS_IRQ_ST)
				irq_st_q <= (irq_st_q & ~i_hwdata[IRQ_W-1:0]) | irq_ev;
			else
				irq_st_q <= irq_st_q | irq_ev;
			if (wr_en && addr_q == OFS_IRQ_MSK)
				irq_msk_q <= i_hwdata[IRQ_W-1:0];
			o_irq <= |(irq_st_q & irq_msk_q);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	chk_scan_first_chan: assert property (
		go && !hp_go && start_ok && scan_now |=>
			o_analog_input_channel == $past(cfg_q.first)
			&& last_q == CH_W'($past(span) - 5'h1))
		else $error("scan did not start at first channel");

	chk_scan_advance: assert property (
		st_q == ST_CONV && done && !srst_q
			&& o_analog_input_channel != last_q |=>
			o_analog_input_channel == $past(o_analog_input_channel) + 4'h1
			##1 kick_q == 1'b0)
		else $error("scan did not step to next channel");

	chk_range_limit: assert property (
		st_q == ST_CONV |-> last_q < CH_W'(CH_NUM))
		else $error("scan ran past last slot");

	chk_refuse_start: assert property (
		st_q == ST_IDLE && go && !hp_go && scan_now && !range_ok
			|=> st_q == ST_IDLE && irq_st_q[IRQ_REFUSE])
		else $error("bad scan range was started");

	chk_hold_bounds: assert property (
		cfg_q.hold >= SH_MIN && cfg_q.hold <= SH_MAX)
		else $error("sample-hold length out of bounds");

	// ticks seen in the hold window
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			hold_ticks_q <= 7'h00;
		else if (!o_sample_hold)
			hold_ticks_q <= 7'h00;
		else if (tick)
			hold_ticks_q <= hold_ticks_q + 7'h01;
	end

	chk_hold_length: assert property (
		$fell(o_sample_hold) && !$past(srst_q) |->
			hold_ticks_q == cfg_q.hold)
		else $error("sample-hold window has wrong length");

	chk_srst_pair: assert property (
		wr_en && addr_q == OFS_SRST && armed_q
			&& i_hwdata[1:0] == SRST_FIRE |=>
			srst_q ##1 st_q == ST_IDLE && !o_sample_hold && !o_converting)
		else $error("soft reset pair did not reinitialise");

	chk_eoc_read_clear: assert property (
		rd_en && addr_q == OFS_STAT && !pass_done && !hp_done
			|=> !eoc_q && !hpeoc_q)
		else $error("completion flag survived a read");

	chk_repeat_busy: assert property (
		pass_done && cfg_q.rpt && !srst_q |=> st_q == ST_CONV && kick_q)
		else $error("repeat mode dropped busy");

	chk_slot_update: assert property (
		st_q == ST_CONV && done && !srst_q |=>
			slot_q[$past(o_analog_input_channel)] == $past(i_conv_data))
		else $error("slot not loaded with newest result");

	cov_scan_done:   cover property (pass_done && cfg_q.scan);
	cov_repeat_pass: cover property (pass_done && cfg_q.rpt);
	cov_refused:     cover property (refuse && scan_now);
	cov_soft_reset:  cover property (srst_q && st_q == ST_CONV);
endmodule : adcsc_ctrl
`default_nettype wire

//--- verification/adcsc_tb.sv
`default_nettype none
module testbench
	import adcsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_clk;
	logic        i_arst_n;
	logic        hsel      = 1'b0;
	logic [31:0] haddr     = 32'h00000000;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [2:0]  hsize     = 3'h2;
	logic [31:0] hwdata    = 32'h00000000;
	logic [11:0] conv_data = 12'h000;
	logic [11:0] base      = 12'h100;
	logic [31:0] hrdata;
	wire logic   hready;
	logic        hresp;
	logic        irq;
	logic [3:0]  chan;
	logic        sh;
	logic        sh_d      = 1'b0;
	int          sh_cnt    = 0;
	int          sh_last   = 0;
	logic        conv;
	logic        conv_d    = 1'b0;
	logic        refon;
	logic [3:0]  seen[$];
	int          n_errors  = 0;
	int          tests_run = 0;
	int          cycles    = 0;
	int          k;
	logic [7:0]  bad_scan[4] = '{8'h49, 8'h2B, 8'h05, 8'h0C};
	logic [7:0]  hold_in[5]  = '{8'h05, 8'h0A, 8'h50, 8'h51, 8'h7F};
	logic [7:0]  hold_ex[5]  = '{8'h0A, 8'h0A, 8'h50, 8'h50, 8'h50};

	adcsc_ctrl uut (
		.i_clk                  (i_clk),
		.i_arst_n               (i_arst_n),
		.i_hsel                 (hsel),
		.i_haddr                (haddr),
		.i_htrans               (htrans),
		.i_hwrite               (hwrite),
		.i_hsize                (hsize),
		.i_hwdata               (hwdata),
		.i_hready               (hready),
		.i_conv_data            (conv_data),
		.o_hrdata               (hrdata),
		.o_hreadyout            (hready),
		.o_hresp                (hresp),
		.o_irq                  (irq),
		.o_analog_input_channel (chan),
		.o_sample_hold          (sh),
		.o_converting           (conv),
		.o_reference_power_on   (refon)
	);

	initial
	begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// ------------------------------------------------------------
	// converter stand-in and channel order monitor
	// ------------------------------------------------------------
	always @(posedge i_clk)
	begin
		conv_data <= base + {8'h00, chan};
		conv_d <= conv;
		sh_d <= sh;
		sh_cnt <= (sh === 1'b1) ? sh_cnt + 1 : 0;
		if (sh === 1'b0 && sh_d === 1'b1)
			sh_last <= sh_cnt;
		if (conv === 1'b1 && conv_d === 1'b0)
			seen.push_back(chan);
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			$display("[FAIL] %0t: run did not finish in time", $time);
			n_errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// single word transfer: address phase, then data phase
	task automatic ahb_xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge i_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge i_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : ahb_xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb_xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb_xfer(1'b0, a, 32'h00000000, q);
		check(q, exp);
	endtask : rd_chk

	// poll a register bit until it reaches a level, bounded
	task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
		logic [31:0] q;
		for (int i = 0; i < 400; i++)
		begin
			ahb_xfer(1'b0, a, 32'h00000000, q);
			if (q[b] === v)
				break;
		end
		check({31'h00000000, q[b]}, {31'h00000000, v});
	endtask : wait_bit

	initial
	begin
		i_arst_n = 1'b0;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		rd_chk(OFS_SCAN, 32'h000000C0);
		rd_chk(OFS_CLKDIV, 32'h00000002);
		rd_chk(OFS_IRQ_MSK, 32'h00000000);
		rd_chk(8'h70, 32'h00000000);
		check({31'h00000000, hresp}, 32'h00000000);
		// ------------------------------------------------------------
		// sample-hold clamp
		// ------------------------------------------------------------
		for (k = 0; k < 5; k++)
		begin
			wr(OFS_HOLD, {24'h000000, hold_in[k]});
			rd_chk(OFS_HOLD, {24'h000000, hold_ex[k]});
		end
		wr(OFS_HOLD, 32'h0000000A);
		// ------------------------------------------------------------
		// refused starts, refuse interrupt raised, cleared, masked
		// ------------------------------------------------------------
		wr(OFS_IRQ_MSK, 32'h00000002);
		for (k = 0; k < 4; k++)
		begin
			wr(OFS_SCAN, {24'h000000, bad_scan[k]});
			wr(OFS_START, 32'h00000005);
			rd_chk(OFS_STAT, 32'h00000000);
			rd_chk(OFS_IRQ_ST, 32'h00000002);
			check({31'h00000000, irq}, 32'h00000001);
			wr(OFS_IRQ_ST, 32'h00000002);
			repeat (2) @(posedge i_clk);
			check({31'h00000000, irq}, 32'h00000000);
		end
		wr(OFS_IRQ_MSK, 32'h00000000);
		wr(OFS_START, 32'h00000005);
		repeat (2) @(posedge i_clk);
		check({31'h00000000, irq}, 32'h00000000);
		wr(OFS_IRQ_ST, 32'h00000007);
		// ------------------------------------------------------------
		// boundary scan, then a second scan overwriting the slots
		// ------------------------------------------------------------
		for (int p = 0; p < 2; p++)
		begin
			base = (p == 0) ? 12'h100 : 12'h200;
			seen.delete();
			wr(OFS_SCAN, 32'h00000039);
			wr(OFS_START, 32'h00000005);
			wait_bit(OFS_IRQ_ST, IRQ_DONE, 1'b1);
			rd_chk(OFS_STAT, 32'h00000002);
			rd_chk(OFS_STAT, 32'h00000000);
			wr(OFS_IRQ_ST, 32'h00000001);
			check(seen.size(), 32'h00000003);
			for (k = 0; k < 3; k++)
			begin
				check({28'h0000000, seen[k]}, 9 + k);
				rd_chk(8'h64 + 4 * k, {20'h00000, base} + 9 + k);
			end
			rd_chk(8'h60, 32'h00000000);
		end
		// ten ticks of four clocks, first tick one to four clocks late
		check(32'(sh_last >= 37 && sh_last <= 40), 32'h00000001);
		base = 12'h280;
		wr(OFS_SCAN, 32'h0000001B);
		wr(OFS_START, 32'h00000005);
		wait_bit(OFS_IRQ_ST, IRQ_DONE, 1'b1);
		rd_chk(8'h6C, 32'h0000028B);
		// ------------------------------------------------------------
		// repeat keeps busy until repeat is off and the pass ends
		// ------------------------------------------------------------
		wr(OFS_IRQ_ST, 32'h00000001);
		wr(OFS_SCAN, 32'h00000003);
		wr(OFS_START, 32'h00000003);
		wait_bit(OFS_IRQ_ST, IRQ_DONE, 1'b1);
		wait_bit(OFS_IRQ_ST, IRQ_DONE, 1'b1);
		wr(OFS_IRQ_ST, 32'h00000001);
		wait_bit(OFS_IRQ_ST, IRQ_DONE, 1'b1);
		rd_chk(OFS_STAT, 32'h00000003);
		wr(OFS_START, 32'h00000000);
		wait_bit(OFS_STAT, STAT_BUSY, 1'b0);
		rd_chk(8'h4C, 32'h00000283);
		// ------------------------------------------------------------
		// stop sequence; a broken soft reset pair does nothing
		// ------------------------------------------------------------
		wr(OFS_REF, 32'h00000001);
		check({31'h00000000, refon}, 32'h00000001);
		wr(OFS_CLKDIV, 32'h00000004);
		wr(OFS_CLKDIV, 32'h00000002);
		wr(OFS_SRST, 32'h00000002);
		wr(OFS_SRST, 32'h00000000);
		wr(OFS_SRST, 32'h00000001);
		rd_chk(8'h64, 32'h00000209);
		wr(OFS_SRST, 32'h00000002);
		wr(OFS_SRST, 32'h00000001);
		rd_chk(8'h64, 32'h00000000);
		rd_chk(8'h4C, 32'h00000000);
		rd_chk(OFS_HOLD, 32'h0000000A);
		rd_chk(OFS_SCAN, 32'h00000003);
		rd_chk(OFS_STAT, 32'h00000000);
		// ------------------------------------------------------------
		// priority conversion after reinitialisation
		// ------------------------------------------------------------
		base = 12'h300;
		wr(OFS_START, 32'h00000008);
		wait_bit(OFS_IRQ_ST, IRQ_HP, 1'b1);
		rd_chk(OFS_STAT, 32'h00000004);
		rd_chk(OFS_STAT, 32'h00000000);
		rd_chk(8'h4C, 32'h00000303);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
